// *** design/ca_ref_pkg.sv ***
// package: constants for the ca reference setting register bank
package ca_ref_pkg;
	// ****************************************
	// register addressing and layout
	// ****************************************
	localparam logic [5:0] CA_REF_ADDR = 6'h0C;
	localparam int LEVEL_LSB = 0;
	localparam int LEVEL_W = 6;
	localparam int RANGE_BIT = 6;
	localparam int RSVD_BIT = 7;
	localparam logic [5:0] LEVEL_MAX = 6'h32;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [5:0] LEVEL_RST = 6'h1D;
	localparam logic RANGE_RST = 1'b1;
	// ****************************************
	// reference scale, tenths of a percent of io supply
	// ****************************************
	localparam logic [9:0] RANGE0_BASE = 10'h096;
	localparam logic [9:0] RANGE1_BASE = 10'h149;
	localparam logic [9:0] STEP_TENTHS = 10'h006;
endpackage

// *** design/ca_ref_setting.sv ***
// module: dual set point ca reference setting register
`timescale 1ns/1ps
module ca_ref_setting
(
	// system
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// link side mode register command port
	input wire logic link_clk_i,
	input wire logic link_nrst_i,
	input wire logic mrw_i,
	input wire logic mrr_i,
	input wire logic [5:0] mr_addr_i,
	input wire logic [7:0] mr_wdata_i,
	input wire logic set_point_access_select_i,
	output logic [7:0] dq_o,
	output logic dq_oe_o,
	// core side
	input wire logic set_point_operate_select_i,
	output logic ca_reference_range_o,
	output logic [5:0] ca_reference_level_o,
	output logic [9:0] ca_reference_tenths_o
);
	import ca_ref_pkg::*;

	// ****************************************
	// link domain register copies
	// ****************************************
	logic [1:0] range_ff, nxt_range;
	logic [5:0] level_ff [2];
	logic [5:0] nxt_level [2];
	logic [7:0] dq_ff, nxt_dq;
	logic oe_ff, nxt_oe;
	logic hit;

	always_comb
	begin
		hit = (mr_addr_i == CA_REF_ADDR);
		nxt_range = range_ff;
		nxt_level[0] = level_ff[0];
		nxt_level[1] = level_ff[1];
		nxt_dq = 8'h00;
		nxt_oe = 1'b0;
		if (mrw_i && hit)
		begin
			nxt_range[set_point_access_select_i] = mr_wdata_i[RANGE_BIT];
			if (mr_wdata_i[LEVEL_LSB +: LEVEL_W] <= LEVEL_MAX)
				nxt_level[set_point_access_select_i] = mr_wdata_i[LEVEL_LSB +: LEVEL_W];
		end
		else if (mrr_i && hit)
		begin
			nxt_oe = 1'b1;
			nxt_dq[RANGE_BIT] = range_ff[set_point_access_select_i];
			nxt_dq[LEVEL_LSB +: LEVEL_W] = level_ff[set_point_access_select_i];
			nxt_dq[RSVD_BIT] = 1'b0;
		end
	end

	always_ff @(posedge link_clk_i)
	begin
		if (!link_nrst_i)
		begin
			range_ff <= {RANGE_RST, RANGE_RST};
			level_ff[0] <= LEVEL_RST;
			level_ff[1] <= LEVEL_RST;
			dq_ff <= 8'h00;
			oe_ff <= 1'b0;
		end
		else
		begin
			range_ff <= nxt_range;
			level_ff[0] <= nxt_level[0];
			level_ff[1] <= nxt_level[1];
			dq_ff <= nxt_dq;
			oe_ff <= nxt_oe;
		end
	end

	assign dq_o = dq_ff;
	assign dq_oe_o = oe_ff;

	// ****************************************
	// link side of the crossing
	// ****************************************
	// snapshot stays still while a request is open, so the core copies a settled word
	logic [1:0] snap_rng_ff, nxt_snap_rng;
	logic [5:0] snap_lvl_ff [2];
	logic [5:0] nxt_snap_lvl [2];
	logic req_ff, nxt_req;
	logic ack_s1_ff, ack_s2_ff;
	logic ack_ff, nxt_ack;
	logic busy;
	logic stale;

	always_comb
	begin
		busy = (req_ff != ack_s2_ff);
		stale = (snap_rng_ff != range_ff)
			|| (snap_lvl_ff[0] != level_ff[0])
			|| (snap_lvl_ff[1] != level_ff[1]);
		nxt_snap_rng = snap_rng_ff;
		nxt_snap_lvl[0] = snap_lvl_ff[0];
		nxt_snap_lvl[1] = snap_lvl_ff[1];
		nxt_req = req_ff;
		if (!busy && stale)
		begin
			nxt_snap_rng = range_ff;
			nxt_snap_lvl[0] = level_ff[0];
			nxt_snap_lvl[1] = level_ff[1];
			nxt_req = !req_ff;
		end
	end

	always_ff @(posedge link_clk_i)
	begin
		if (!link_nrst_i)
		begin
			snap_rng_ff <= {RANGE_RST, RANGE_RST};
			snap_lvl_ff[0] <= LEVEL_RST;
			snap_lvl_ff[1] <= LEVEL_RST;
			req_ff <= 1'b0;
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
		end
		else
		begin
			snap_rng_ff <= nxt_snap_rng;
			snap_lvl_ff[0] <= nxt_snap_lvl[0];
			snap_lvl_ff[1] <= nxt_snap_lvl[1];
			req_ff <= nxt_req;
			ack_s1_ff <= ack_ff;
			ack_s2_ff <= ack_s1_ff;
		end
	end

	// ****************************************
	// core side of the crossing
	// ****************************************
	// both resets are meant to be applied together; a lone core reset shows
	// the default setting until the next write reaches the copies if req_ff is 0; if req_ff is 1 the core copies the snapshot again
	logic req_s1_ff, req_s2_ff;
	logic [1:0] held_rng_ff, nxt_held_rng;
	logic [5:0] held_lvl_ff [2];
	logic [5:0] nxt_held_lvl [2];

	always_comb
	begin
		nxt_ack = ack_ff;
		nxt_held_rng = held_rng_ff;
		nxt_held_lvl[0] = held_lvl_ff[0];
		nxt_held_lvl[1] = held_lvl_ff[1];
		if (req_s2_ff != ack_ff)
		begin
			nxt_held_rng = snap_rng_ff;
			nxt_held_lvl[0] = snap_lvl_ff[0];
			nxt_held_lvl[1] = snap_lvl_ff[1];
			nxt_ack = req_s2_ff;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			req_s1_ff <= 1'b0;
			req_s2_ff <= 1'b0;
			ack_ff <= 1'b0;
			held_rng_ff <= {RANGE_RST, RANGE_RST};
			held_lvl_ff[0] <= LEVEL_RST;
			held_lvl_ff[1] <= LEVEL_RST;
		end
		else
		begin
			req_s1_ff <= req_ff;
			req_s2_ff <= req_s1_ff;
			ack_ff <= nxt_ack;
			held_rng_ff <= nxt_held_rng;
			held_lvl_ff[0] <= nxt_held_lvl[0];
			held_lvl_ff[1] <= nxt_held_lvl[1];
		end
	end

	// ****************************************
	// active set point outputs
	// ****************************************
	logic op_s1_ff, op_s2_ff;
	logic rng_ff, nxt_rng;
	logic [5:0] lvl_ff, nxt_lvl;
	logic [9:0] tenths_ff, nxt_tenths;

	always_comb
	begin
		nxt_rng = held_rng_ff[op_s2_ff];
		nxt_lvl = held_lvl_ff[op_s2_ff];
		nxt_tenths = (nxt_rng ? RANGE1_BASE : RANGE0_BASE)
			+ 10'(nxt_lvl * STEP_TENTHS);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
		begin
			op_s1_ff <= 1'b0;
			op_s2_ff <= 1'b0;
			rng_ff <= RANGE_RST;
			lvl_ff <= LEVEL_RST;
			tenths_ff <= (RANGE_RST ? RANGE1_BASE : RANGE0_BASE)
				+ 10'(LEVEL_RST * STEP_TENTHS);
		end
		else
		begin
			op_s1_ff <= set_point_operate_select_i;
			op_s2_ff <= op_s1_ff;
			rng_ff <= nxt_rng;
			lvl_ff <= nxt_lvl;
			tenths_ff <= nxt_tenths;
		end
	end

	assign ca_reference_range_o = rng_ff;
	assign ca_reference_level_o = lvl_ff;
	assign ca_reference_tenths_o = tenths_ff;
endmodule

// *** dv/ca_ref_setting_assertions.sv ***
// checker: port assertions of the ca reference register
`timescale 1ns/1ps
module ca_ref_setting_assertions
(
	// clocks and resets
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic link_clk_i,
	input wire logic link_nrst_i,
	// mode register command port
	input wire logic mrw_i,
	input wire logic mrr_i,
	input wire logic [5:0] mr_addr_i,
	input wire logic [7:0] dq_o,
	input wire logic dq_oe_o,
	// core side
	input wire logic ca_reference_range_o,
	input wire logic [5:0] ca_reference_level_o,
	input wire logic [9:0] ca_reference_tenths_o
);
	import ca_ref_pkg::*;
	a_read_answer: assert property (@(posedge link_clk_i) disable iff (!link_nrst_i)
		mrr_i && !mrw_i && mr_addr_i == CA_REF_ADDR |=> dq_oe_o) else $error("no answer");
	a_answer_cause: assert property (@(posedge link_clk_i) disable iff (!link_nrst_i)
		dq_oe_o |-> $past(mrr_i && !mrw_i && mr_addr_i == CA_REF_ADDR)) else $error("stray answer");
	a_rsvd_zero: assert property (@(posedge link_clk_i) disable iff (!link_nrst_i)
		dq_oe_o |-> !dq_o[RSVD_BIT]) else $error("bit7 set");
	a_dq_quiet: assert property (@(posedge link_clk_i) disable iff (!link_nrst_i)
		!dq_oe_o |-> dq_o == 8'h00) else $error("dq not zero");
	a_link_idle: assert property (@(posedge link_clk_i) disable iff (!link_nrst_i)
		$rose(link_nrst_i) |-> !dq_oe_o) else $error("oe after reset");
	a_level_legal: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		ca_reference_level_o <= LEVEL_MAX) else $error("reserved level");
	a_tenths_scale: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		ca_reference_tenths_o == (ca_reference_range_o ? RANGE1_BASE : RANGE0_BASE)
		+ STEP_TENTHS * ca_reference_level_o) else $error("bad tenths");
	a_reset_default: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$rose(nrst_i) |-> ca_reference_range_o && ca_reference_level_o == LEVEL_RST)
		else $error("bad default");
endmodule

// *** dv/ca_ref_setting_tb.sv ***
// testbench: ca reference register with command issuer
`timescale 1ns/1ps
module ca_ref_setting_tb;
	import ca_ref_pkg::*;
	logic sys_clk_i = 0, link_clk_i = 0, nrst_i = 0, set_point_operate_select_i = 0;
	logic mrw_i, mrr_i, set_point_access_select_i, dq_oe_o, ca_reference_range_o;
	logic [5:0] mr_addr_i, ca_reference_level_o;
	logic [7:0] mr_wdata_i, dq_o;
	logic [9:0] ca_reference_tenths_o;
	wire logic link_nrst_i = nrst_i;
	int err_count = 0, samples_checked = 0;
	initial forever #5 sys_clk_i = ~sys_clk_i;
	initial #1.3 forever #3 link_clk_i = ~link_clk_i;
	ca_ref_setting dut (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.link_clk_i(link_clk_i),
		.link_nrst_i(link_nrst_i),
		.mrw_i(mrw_i),
		.mrr_i(mrr_i),
		.mr_addr_i(mr_addr_i),
		.mr_wdata_i(mr_wdata_i),
		.set_point_access_select_i(set_point_access_select_i),
		.dq_o(dq_o),
		.dq_oe_o(dq_oe_o),
		.set_point_operate_select_i(set_point_operate_select_i),
		.ca_reference_range_o(ca_reference_range_o),
		.ca_reference_level_o(ca_reference_level_o),
		.ca_reference_tenths_o(ca_reference_tenths_o)
	);
	mr_ctrl_model mc (.link_clk_i(link_clk_i), .mrw_o(mrw_i), .mrr_o(mrr_i),
		.sel_o(set_point_access_select_i), .addr_o(mr_addr_i), .wdata_o(mr_wdata_i));
	task chk(input logic [9:0] s, e);
		samples_checked++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch %0t %h %h", $time, s, e);
		end
	endtask
	task rd(input logic s, input logic [7:0] e);
		mc.cmd(1'b0, s, CA_REF_ADDR, 8'h00);
		#1 chk({1'b0, dq_oe_o, dq_o}, {2'b01, e});
	endtask
	task t_copies;
		rd(1'b0, 8'h5D);
		mc.cmd(1'b1, 1'b1, CA_REF_ADDR, 8'h85);
		rd(1'b1, 8'h05);
		rd(1'b0, 8'h5D);
		repeat (10) @(posedge sys_clk_i);
		#1 chk(ca_reference_tenths_o, 10'h1F7);
		@(posedge sys_clk_i);
		set_point_operate_select_i <= 1'b1;
		repeat (10) @(posedge sys_clk_i);
		#1 chk(ca_reference_tenths_o, 10'h0B4);
		chk({9'h000, ca_reference_range_o}, 10'h000);
		chk({4'h0, ca_reference_level_o}, 10'h005);
	endtask
	task t_refused;
		mc.cmd(1'b1, 1'b1, CA_REF_ADDR, 8'h73);
		mc.cmd(1'b0, 1'b1, 6'h0D, 8'h00);
		#1 chk({9'h000, dq_oe_o}, 10'h000);
		rd(1'b1, 8'h45);
		mc.cmd(1'b1, 1'b0, CA_REF_ADDR, 8'h32);
		rd(1'b0, 8'h32);
		repeat (10) @(posedge sys_clk_i);
		#1 chk(ca_reference_tenths_o, 10'h167);
	endtask
	task t_reset;
		@(posedge sys_clk_i);
		nrst_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		#1 chk(ca_reference_tenths_o, 10'h1F7);
		chk({4'h0, ca_reference_level_o}, 10'h01D);
		rd(1'b1, 8'h5D);
	endtask
	task end_sim;
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge sys_clk_i);
		nrst_i <= 1;
		repeat (4) @(posedge sys_clk_i);
		t_copies;
		t_refused;
		t_reset;
		end_sim;
	end
	initial
	begin
		#20000;
		err_count++;
		end_sim;
	end
endmodule
bind ca_ref_setting ca_ref_setting_assertions chk_i (
	.sys_clk_i(sys_clk_i),
	.nrst_i(nrst_i),
	.link_clk_i(link_clk_i),
	.link_nrst_i(link_nrst_i),
	.mrw_i(mrw_i),
	.mrr_i(mrr_i),
	.mr_addr_i(mr_addr_i),
	.dq_o(dq_o),
	.dq_oe_o(dq_oe_o),
	.ca_reference_range_o(ca_reference_range_o),
	.ca_reference_level_o(ca_reference_level_o),
	.ca_reference_tenths_o(ca_reference_tenths_o)
);

// *** dv/mr_ctrl_model.sv ***
// partner: mode register command issuer on the link clock
`timescale 1ns/1ps
module mr_ctrl_model
(
	// link clock
	input wire logic link_clk_i,
	// command outputs
	output logic mrw_o,
	output logic mrr_o,
	output logic sel_o,
	output logic [5:0] addr_o,
	output logic [7:0] wdata_o
);
	initial
	begin
		{mrw_o, mrr_o, sel_o, addr_o, wdata_o} = '0;
	end
	task automatic cmd(input logic w, s, input logic [5:0] a, input logic [7:0] d);
		@(posedge link_clk_i);
		{mrw_o, mrr_o, sel_o, addr_o, wdata_o} <= {w, !w, s, a, d};
		@(posedge link_clk_i);
		{mrw_o, mrr_o, addr_o, wdata_o} <= {2'b00, ~a, ~d};
	endtask
endmodule
